// [rtl/lda_pkg.sv]
package lda_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  LDA_DEST_OFFSET   = 8'h00;
    localparam logic [7:0]  LDA_STATUS_OFFSET = 8'h04;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int          LDA_BASE_LSB      = 10;
    localparam int          LDA_BASE_MSB      = 28;
    localparam int          LDA_BASE_WIDTH    = 19;
    localparam int          LDA_SEL_LSB       = 0;
    localparam int          LDA_SEL_WIDTH     = 6;
    localparam int          LDA_ADDR_WIDTH    = 29;

    // ------------------------------------------------------------
    // Reset values (base and select are undefined; zero chosen)
    // ------------------------------------------------------------
    localparam logic [18:0] LDA_BASE_RESET    = 19'h00000;
    localparam logic [5:0]  LDA_SEL_RESET     = 6'h00;

    // Status register bit positions
    localparam int          LDA_ST_APPLIED    = 0;
    localparam int          LDA_ST_LEGAL      = 1;
    localparam int          LDA_ST_WRITTEN    = 2;

    typedef struct packed {
        logic [18:0] base;
        logic [5:0]  sel;
    } lda_reg_type;

    typedef enum logic [0:0] {
        LDA_BUS_IDLE,
        LDA_BUS_ACK
    } lda_bus_state_type;

endpackage : lda_pkg

// [rtl/lda_bit_mux.sv]
`timescale 1ns/100ps
module lda_bit_mux
    import lda_pkg::*;
(
    // Choice
    input  wire logic sel_i,
    // Sources
    input  wire logic operand_i,
    input  wire logic base_i,
    // Result
    output logic      addr_o
);
    assign addr_o = sel_i ? base_i : operand_i;
endmodule : lda_bit_mux

// [rtl/lda_dest_addr.sv]
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/100ps
module lda_dest_addr
    import lda_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Mode bits from the processor
    input  wire logic        translation_on_bit_i,
    input  wire logic        local_ram_protect_bit_i,
    // Transfer address path
    input  wire logic        xfer_req_i,
    input  wire logic [28:0] operand_addr_i,
    output logic      [28:0] dest_addr_o,
    output logic             dest_valid_o,
    output logic             reg_applied_o
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    lda_reg_type       page0_dest_address_reg;
    lda_reg_type       next_page0_dest_address_reg;
    // Set on the first write; only reset clears it
    logic              written;
    logic              next_written;
    lda_bus_state_type bus_state;
    lda_bus_state_type next_bus_state;
    logic              ack;
    logic              next_ack;
    // Read word is held until the next request
    logic [31:0]       rdata;
    logic [31:0]       next_rdata;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic              req;
    logic              hit_dest;
    logic              hit_status;
    logic              sel_legal;
    logic              applied;
    logic [31:0]       dest_image;
    logic [31:0]       status_image;
    logic [31:0]       lane_mask;
    logic [31:0]       merged_image;

    assign req        = wb_cyc_i && wb_stb_i;
    assign hit_dest   = (wb_adr_i == LDA_DEST_OFFSET);
    assign hit_status = (wb_adr_i == LDA_STATUS_OFFSET);
    // Not applied only when both translation and protection are on
    assign applied = !(translation_on_bit_i && local_ram_protect_bit_i);

    // Only the seven high-order patterns are legal; flag others to software
    always_comb begin
        case (page0_dest_address_reg.sel)
            6'h3f, 6'h3e, 6'h3c, 6'h38, 6'h30, 6'h20, 6'h00: sel_legal = 1'b1;
            default: sel_legal = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Read images and write merge
    // ------------------------------------------------------------
    // Reserved positions are never loaded, so they always read zero
    always_comb begin
        dest_image                              = 32'h00000000;
        dest_image[LDA_BASE_MSB:LDA_BASE_LSB]   = page0_dest_address_reg.base;
        dest_image[LDA_SEL_WIDTH-1:LDA_SEL_LSB] = page0_dest_address_reg.sel;
    end

    always_comb begin
        status_image                 = 32'h00000000;
        status_image[LDA_ST_APPLIED] = applied;
        status_image[LDA_ST_LEGAL]   = sel_legal;
        status_image[LDA_ST_WRITTEN] = written;
    end

    // Byte enables pick which lanes of the write word replace the image
    always_comb begin
        lane_mask = 32'h00000000;
        for (int lane = 0; lane < 4; lane++) begin
            lane_mask[8*lane +: 8] = {8{wb_sel_i[lane]}};
        end
        merged_image = (wb_dat_i & lane_mask) | (dest_image & ~lane_mask);
    end

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    always_comb begin
        next_page0_dest_address_reg = page0_dest_address_reg;
        next_written                = written;
        next_bus_state              = bus_state;
        next_ack                    = 1'b0;
        next_rdata                  = rdata;
        case (bus_state)
            LDA_BUS_IDLE: begin
                if (req) begin
                    next_bus_state = LDA_BUS_ACK;
                    next_ack       = 1'b1;
                    next_rdata     = 32'h00000000;
                    if (hit_dest) begin
                        next_rdata = dest_image;
                        if (wb_we_i) begin
                            // Reserved bits of the write word are dropped here
                            next_page0_dest_address_reg.base =
                                merged_image[LDA_BASE_MSB:LDA_BASE_LSB];
                            next_page0_dest_address_reg.sel  =
                                merged_image[LDA_SEL_WIDTH-1:LDA_SEL_LSB];
                            next_written = 1'b1;
                        end
                    end else if (hit_status) begin
                        // Status is read only; writes are acknowledged and dropped
                        next_rdata = status_image;
                    end
                end
            end
            LDA_BUS_ACK: begin
                next_bus_state = LDA_BUS_IDLE;
            end
            default: begin
                next_bus_state = LDA_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            page0_dest_address_reg.base <= LDA_BASE_RESET;
            page0_dest_address_reg.sel  <= LDA_SEL_RESET;
            written                     <= 1'b0;
            bus_state                   <= LDA_BUS_IDLE;
            ack                         <= 1'b0;
            rdata                       <= 32'h00000000;
        end else begin
            page0_dest_address_reg <= next_page0_dest_address_reg;
            written                <= next_written;
            bus_state              <= next_bus_state;
            ack                    <= next_ack;
            rdata                  <= next_rdata;
        end
    end

    // Ack comes from its own flop, never decoded from the state
    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;

    // ------------------------------------------------------------
    // Destination address forming
    // ------------------------------------------------------------
    logic [5:0]  mixed_bits;
    logic [28:0] next_dest_addr;
    logic        next_dest_valid;
    logic        next_reg_applied;
    logic [28:0] dest_addr;
    logic        dest_valid;
    logic        reg_applied;

    // One mux per window bit; bits above the window never mix
    genvar g;
    generate
        for (g = 0; g < LDA_SEL_WIDTH; g++) begin : g_mux
            lda_bit_mux u_mux (
                .sel_i     (page0_dest_address_reg.sel[g]),
                .operand_i (operand_addr_i[LDA_BASE_LSB + g]),
                .base_i    (page0_dest_address_reg.base[g]),
                .addr_o    (mixed_bits[g])
            );
        end
    endgenerate

    // Bits below the window always come from the operand
    always_comb begin
        next_dest_addr   = operand_addr_i;
        next_dest_valid  = xfer_req_i;
        next_reg_applied = applied;
        if (applied) begin
            next_dest_addr[LDA_BASE_MSB:LDA_BASE_LSB+LDA_SEL_WIDTH] =
                page0_dest_address_reg.base[LDA_BASE_WIDTH-1:LDA_SEL_WIDTH];
            next_dest_addr[LDA_BASE_LSB+LDA_SEL_WIDTH-1:LDA_BASE_LSB] = mixed_bits;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dest_addr   <= 29'h0000000;
            dest_valid  <= 1'b0;
            reg_applied <= 1'b0;
        end else begin
            dest_addr   <= next_dest_addr;
            dest_valid  <= next_dest_valid;
            reg_applied <= next_reg_applied;
        end
    end

    // ------------------------------------------------------------
    // Output ports
    // ------------------------------------------------------------
    assign dest_addr_o   = dest_addr;
    assign dest_valid_o  = dest_valid;
    assign reg_applied_o = reg_applied;

endmodule : lda_dest_addr

// [bench/lda_dest_addr_properties.sv]
`timescale 1ns/100ps
module lda_dest_addr_properties
    import lda_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        translation_on_bit_i,
    input wire logic        local_ram_protect_bit_i,
    input wire logic        xfer_req_i,
    input wire logic [28:0] operand_addr_i,
    input wire logic [28:0] dest_addr_o,
    input wire logic        dest_valid_o,
    input wire logic        reg_applied_o
);
    // Shadow of the register, taken at the same edge as the design's write
    logic [18:0] sb, next_sb;
    logic [5:0]  ss, next_ss;
    logic        wr;
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o & (wb_adr_i == LDA_DEST_OFFSET);
    always_comb begin
        next_sb = sb;
        next_ss = ss;
        if (wr && wb_sel_i[3]) next_sb[18:14] = wb_dat_i[28:24];
        if (wr && wb_sel_i[2]) next_sb[13:6] = wb_dat_i[23:16];
        if (wr && wb_sel_i[1]) next_sb[5:0] = wb_dat_i[15:10];
        if (wr && wb_sel_i[0]) next_ss = wb_dat_i[5:0];
    end
    always_ff @(posedge clk_i) begin
        sb <= rst_i ? LDA_BASE_RESET : next_sb;
        ss <= rst_i ? LDA_SEL_RESET : next_ss;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    apply_flag_a: assert property (!$past(rst_i) |-> reg_applied_o ==
        !$past(translation_on_bit_i && local_ram_protect_bit_i)) else $error("applied flag");
    pass_thru_a: assert property (dest_valid_o && !reg_applied_o |->
        dest_addr_o == $past(operand_addr_i)) else $error("bypass address");
    base_high_a: assert property (dest_valid_o && reg_applied_o |->
        dest_addr_o[28:16] == $past(sb[18:6])) else $error("base bits");
    sel_zero_a: assert property (dest_valid_o && reg_applied_o |->
        ((dest_addr_o[15:10] ^ $past(operand_addr_i[15:10])) & ~$past(ss)) == 6'h00)
        else $error("operand bits");
    sel_one_a: assert property (dest_valid_o && reg_applied_o |->
        ((dest_addr_o[15:10] ^ $past(sb[5:0])) & $past(ss)) == 6'h00)
        else $error("base low bits");
    low_bits_a: assert property (dest_valid_o |->
        dest_addr_o[9:0] == $past(operand_addr_i[9:0])) else $error("low bits");
    read_back_a: assert property (wb_ack_o && !$past(wb_we_i) &&
        $past(wb_adr_i) == LDA_DEST_OFFSET |-> wb_dat_o == {3'h0, sb, 4'h0, ss})
        else $error("read data");
endmodule : lda_dest_addr_properties
bind lda_dest_addr lda_dest_addr_properties lda_dest_addr_properties_inst (
    .clk_i                   (clk_i),
    .rst_i                   (rst_i),
    .wb_cyc_i                (wb_cyc_i),
    .wb_stb_i                (wb_stb_i),
    .wb_we_i                 (wb_we_i),
    .wb_adr_i                (wb_adr_i),
    .wb_sel_i                (wb_sel_i),
    .wb_dat_i                (wb_dat_i),
    .wb_dat_o                (wb_dat_o),
    .wb_ack_o                (wb_ack_o),
    .translation_on_bit_i    (translation_on_bit_i),
    .local_ram_protect_bit_i (local_ram_protect_bit_i),
    .xfer_req_i              (xfer_req_i),
    .operand_addr_i          (operand_addr_i),
    .dest_addr_o             (dest_addr_o),
    .dest_valid_o            (dest_valid_o),
    .reg_applied_o           (reg_applied_o)
);

// [bench/tb_lda_dest_addr.sv]
`timescale 1ns/100ps
module tb_lda_dest_addr;
    import lda_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic xfer_req_i = 1'b0, translation_on_bit_i = 1'b0, local_ram_protect_bit_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, d;
    logic [28:0] operand_addr_i = 29'h0, dest_addr_o;
    logic        wb_ack_o, dest_valid_o, reg_applied_o;
    logic [18:0] mb;
    logic [5:0]  ms;
    logic [5:0]  pats[$] = '{6'h3f, 6'h3e, 6'h3c, 6'h38, 6'h30, 6'h20, 6'h00};
    int          bad_count = 0, check_count = 0, seed;
    lda_dest_addr lda_dest_addr_inst (
        .clk_i                   (clk_i),
        .rst_i                   (rst_i),
        .wb_cyc_i                (wb_cyc_i),
        .wb_stb_i                (wb_stb_i),
        .wb_we_i                 (wb_we_i),
        .wb_adr_i                (wb_adr_i),
        .wb_sel_i                (wb_sel_i),
        .wb_dat_i                (wb_dat_i),
        .wb_dat_o                (wb_dat_o),
        .wb_ack_o                (wb_ack_o),
        .translation_on_bit_i    (translation_on_bit_i),
        .local_ram_protect_bit_i (local_ram_protect_bit_i),
        .xfer_req_i              (xfer_req_i),
        .operand_addr_i          (operand_addr_i),
        .dest_addr_o             (dest_addr_o),
        .dest_valid_o            (dest_valid_o),
        .reg_applied_o           (reg_applied_o)
    );
    always #4 clk_i = ~clk_i;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic close_out();
        if (bad_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    // Waits for ack without a limit of its own; the watchdog ends a hang
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] dt, input logic [3:0] s);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, dt, s};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb
    task automatic wr_model(input logic [31:0] dt, input logic [3:0] s);
        if (s[3]) mb[18:14] = dt[28:24];
        if (s[2]) mb[13:6] = dt[23:16];
        if (s[1]) mb[5:0] = dt[15:10];
        if (s[0]) ms = dt[5:0];
    endtask : wr_model
    task automatic rd_reg();
        wb(1'b0, LDA_DEST_OFFSET, 32'h0, 4'hf);
        chk("dest reg", rd, {3'h0, mb, 4'h0, ms});
    endtask : rd_reg
    task automatic rd_status(input logic wrt);
        logic ok, ap;
        ok = 1'b0;
        foreach (pats[i]) begin
            if (pats[i] == ms) begin
                ok = 1'b1;
            end
        end
        ap = !(translation_on_bit_i && local_ram_protect_bit_i);
        wb(1'b0, LDA_STATUS_OFFSET, 32'h0, 4'hf);
        chk("status", rd, {29'h0, wrt, ok, ap});
    endtask : rd_status
    task automatic xfer(input logic tr, input logic pr);
        logic [28:0] op, e;
        op = 29'($random(seed));
        e = op;
        if (!(tr && pr)) e = {mb[18:6], (ms & mb[5:0]) | (~ms & op[15:10]), op[9:0]};
        @(posedge clk_i);
        {xfer_req_i, operand_addr_i} <= {1'b1, op};
        {translation_on_bit_i, local_ram_protect_bit_i} <= {tr, pr};
        repeat (2) @(posedge clk_i);
        chk("dest addr", dest_addr_o, e);
        chk("applied", reg_applied_o, !(tr && pr));
        chk("valid", dest_valid_o, 1'b1);
        xfer_req_i <= 1'b0;
    endtask : xfer
    initial begin
        seed = 90;
        mb = LDA_BASE_RESET;
        ms = LDA_SEL_RESET;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_reg();
        rd_status(1'b0);
        foreach (pats[i]) begin
            d = $random(seed);
            d[5:0] = pats[i];
            wb(1'b1, LDA_DEST_OFFSET, d, 4'hf);
            wr_model(d, 4'hf);
            rd_reg();
            for (int m = 0; m < 4; m++) xfer(m[1], m[0]);
        end
        // Single byte lane: other fields must keep their old contents
        d = $random(seed);
        wb(1'b1, LDA_DEST_OFFSET, d, 4'h4);
        wr_model(d, 4'h4);
        rd_reg();
        wb(1'b1, 8'h08, 32'hffffffff, 4'hf);
        wb(1'b0, 8'h08, 32'h0, 4'hf);
        chk("unmapped", rd, 32'h0);
        rd_reg();
        // Status is read only: a write must change nothing
        wb(1'b1, LDA_STATUS_OFFSET, 32'hffffffff, 4'hf);
        rd_reg();
        rd_status(1'b1);
        // Reset in mid-run: fields and the written flag return to zero
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        mb = LDA_BASE_RESET;
        ms = LDA_SEL_RESET;
        rd_reg();
        rd_status(1'b0);
        xfer(1'b0, 1'b1);
        rd_status(1'b0);
        close_out();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        bad_count++;
        close_out();
    end
endmodule : tb_lda_dest_addr
